// file: rtl/cgl_pkg.sv
// Package for the camera GPIO line control block
package cgl_pkg;
  localparam int LINE_COUNT = 4;
  localparam int USER_OUT_COUNT = 4;
  localparam int CLK_MHZ = 125;
  localparam int CYCLES_PER_US = CLK_MHZ;
  localparam int WIDTH_US_BITS = 16;
  localparam int COUNT_BITS = 24;
  // Register word indexes times four give byte addresses
  localparam logic [7:0] OFF_LINE_INDEX = 8'h00;
  localparam logic [7:0] OFF_LINE_MODE = 8'h04;
  localparam logic [7:0] OFF_AUX_RAIL = 8'h08;
  localparam logic [7:0] OFF_INVERT = 8'h0C;
  localparam logic [7:0] OFF_LEVEL = 8'h10;
  localparam logic [7:0] OFF_ALL_LEVELS = 8'h14;
  localparam logic [7:0] OFF_FILTER_CHOICE = 8'h18;
  localparam logic [7:0] OFF_FILTER_WIDTH = 8'h1C;
  localparam logic [7:0] OFF_SOURCE = 8'h20;
  localparam logic [7:0] OFF_DRIVER_KIND = 8'h24;
  localparam logic [7:0] OFF_SOFT_INDEX = 8'h28;
  localparam logic [7:0] OFF_SOFT_LEVEL = 8'h2C;
  localparam logic [7:0] OFF_SOFT_VECTOR = 8'h30;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // Filter choice selects which width register is addressed
  localparam logic FILTER_DEGLITCH = 1'b0;
  localparam logic FILTER_DEBOUNCE = 1'b1;
  // Driver kinds
  localparam logic [1:0] KIND_TRI_STATE = 2'h0;
  localparam logic [1:0] KIND_OPTO = 2'h1;
  localparam logic [1:0] KIND_OPEN_DRAIN = 2'h2;
  // Output source codes
  localparam logic [3:0] SRC_LINE0 = 4'h0;
  localparam logic [3:0] SRC_USER0 = 4'h4;
  localparam logic [3:0] SRC_COUNTER0 = 4'h8;
  localparam logic [3:0] SRC_COUNTER1 = 4'h9;
  localparam logic [3:0] SRC_LOGIC0 = 4'hA;
  localparam logic [3:0] SRC_LOGIC1 = 4'hB;
  localparam logic [3:0] SRC_EXPOSURE = 4'hC;
  localparam logic [3:0] SRC_TRIG_READY = 4'hD;
  localparam logic [3:0] SRC_LAST = 4'hD;
  typedef struct packed {
    logic output_mode;
    logic invert;
    logic aux_rail;
    logic [WIDTH_US_BITS-1:0] deglitch_us;
    logic [WIDTH_US_BITS-1:0] debounce_us;
    logic [3:0] source;
  } cgl_line_cfg_type;
  localparam cgl_line_cfg_type LINE_CFG_RESET = '0;
  typedef struct packed {
    logic [1:0] counter_active;
    logic [1:0] logic_block;
    logic exposure_active;
    logic trigger_ready;
  } cgl_internal_type;
endpackage : cgl_pkg

// file: rtl/cgl_line_filter.sv
// Per-line deglitch followed by debounce input filter
`timescale 1ns/1ns
`default_nettype none
module cgl_line_filter #(
  parameter int COUNT_BITS = cgl_pkg::COUNT_BITS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic raw_in,
  input wire logic [COUNT_BITS-1:0] deglitch_cycles,
  input wire logic [COUNT_BITS-1:0] debounce_cycles,
  output logic filtered
);
  logic glitch_reg, glitch_next;
  logic [COUNT_BITS-1:0] gcount_reg, gcount_next;
  logic bounce_reg, bounce_next;
  logic [COUNT_BITS-1:0] bcount_reg, bcount_next;

  always_comb
  begin
    glitch_next = glitch_reg;
    gcount_next = '0;
    // New state accepted only after holding the full width
    if (raw_in != glitch_reg)
    begin
      gcount_next = gcount_reg + 1'b1;
      if (gcount_reg + 1'b1 >= deglitch_cycles)
      begin
        glitch_next = raw_in;
        gcount_next = '0;
      end
    end
    bounce_next = bounce_reg;
    bcount_next = (bcount_reg != '0) ? bcount_reg - 1'b1 : bcount_reg;
    // Deglitch output feeds debounce; first edge passes at once
    if (bcount_reg == '0 && glitch_reg != bounce_reg)
    begin
      bounce_next = glitch_reg;
      bcount_next = debounce_cycles;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      glitch_reg <= 1'b0;
      gcount_reg <= '0;
      bounce_reg <= 1'b0;
      bcount_reg <= '0;
    end
    else
    begin
      glitch_reg <= glitch_next;
      gcount_reg <= gcount_next;
      bounce_reg <= bounce_next;
      bcount_reg <= bcount_next;
    end
  end

  assign filtered = bounce_reg;
endmodule : cgl_line_filter
`default_nettype wire

// file: rtl/cgl_gpio_lines.sv
// Camera GPIO line control: configuration, filtering, source selection
`timescale 1ns/1ns
`default_nettype none
module cgl_gpio_lines #(
  parameter int LINES = cgl_pkg::LINE_COUNT,
  parameter int USER_OUTS = cgl_pkg::USER_OUT_COUNT,
  parameter logic [LINES-1:0] AUX_RAIL_CAPABLE = 4'h4,
  parameter logic [2*LINES-1:0] DRIVER_KINDS = 8'h25
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [LINES-1:0] pin_in,
  output logic [LINES-1:0] pin_out,
  output logic [LINES-1:0] pin_oe_n,
  output logic [LINES-1:0] aux_rail_enable,
  input wire cgl_pkg::cgl_internal_type internal_in,
  output logic [USER_OUTS-1:0] soft_out_vector
);
  typedef enum logic [1:0] {ST_IDLE, ST_DONE} cgl_bus_state_type;
  cgl_bus_state_type state_reg, state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wait_reg, wait_next;
  logic [1:0] io_line_index_reg, io_line_index_next;
  logic input_filter_choice_reg, input_filter_choice_next;
  logic [1:0] soft_out_index_reg, soft_out_index_next;
  logic [USER_OUTS-1:0] soft_reg, soft_next;
  cgl_pkg::cgl_line_cfg_type cfg_reg [LINES];
  cgl_pkg::cgl_line_cfg_type cfg_next [LINES];
  logic [LINES-1:0] in_sync_reg, filtered, level_vec;
  logic [LINES-1:0] drive_reg, drive_next, oe_n_reg, oe_n_next, rail_reg, rail_next;
  logic [LINES-1:0] all_pin_levels;
  logic [LINES-1:0] src_value;
  cgl_pkg::cgl_line_cfg_type sel_cfg;
  logic [1:0] sel;
  logic wr, rd;

  assign sel = io_line_index_reg;
  assign sel_cfg = cfg_reg[sel];
  assign wr = avs_write && state_reg == ST_DONE && avs_byteenable[0];
  assign rd = avs_read && state_reg == ST_IDLE;

  // Per-line filter and source mux
  genvar g;
  generate
    for (g = 0; g < LINES; g++)
    begin : gen_line
      logic [cgl_pkg::COUNT_BITS-1:0] dg_cyc, db_cyc;
      logic raw;
      // Widths in microseconds scaled to clock cycles
      assign dg_cyc = cgl_pkg::COUNT_BITS'(cfg_reg[g].deglitch_us * cgl_pkg::CYCLES_PER_US);
      assign db_cyc = cgl_pkg::COUNT_BITS'(cfg_reg[g].debounce_us * cgl_pkg::CYCLES_PER_US);
      assign raw = in_sync_reg[g] ^ cfg_reg[g].invert;
      cgl_line_filter #(
        .COUNT_BITS(cgl_pkg::COUNT_BITS)
      ) u_filter (
        .clock(clock),
        .rst(rst),
        .raw_in(raw),
        .deglitch_cycles(dg_cyc),
        .debounce_cycles(db_cyc),
        .filtered(filtered[g])
      );
      // Output lines report their source value before inversion, input lines the filtered pin
      assign level_vec[g] = cfg_reg[g].output_mode ? src_value[g] : filtered[g];
      always_comb
      begin
        src_value[g] = 1'b0;
        if (cfg_reg[g].source < cgl_pkg::SRC_USER0)
          src_value[g] = filtered[cfg_reg[g].source[1:0]];
        else if (cfg_reg[g].source < cgl_pkg::SRC_COUNTER0)
          src_value[g] = soft_reg[cfg_reg[g].source[1:0]];
        else if (cfg_reg[g].source == cgl_pkg::SRC_COUNTER0)
          src_value[g] = internal_in.counter_active[0];
        else if (cfg_reg[g].source == cgl_pkg::SRC_COUNTER1)
          src_value[g] = internal_in.counter_active[1];
        else if (cfg_reg[g].source == cgl_pkg::SRC_LOGIC0)
          src_value[g] = internal_in.logic_block[0];
        else if (cfg_reg[g].source == cgl_pkg::SRC_LOGIC1)
          src_value[g] = internal_in.logic_block[1];
        else if (cfg_reg[g].source == cgl_pkg::SRC_EXPOSURE)
          src_value[g] = internal_in.exposure_active;
        else if (cfg_reg[g].source == cgl_pkg::SRC_TRIG_READY)
          src_value[g] = internal_in.trigger_ready;
      end
      always_comb
      begin
        // Open drain: drive low only, release otherwise
        drive_next[g] = 1'b0;
        oe_n_next[g] = ~(cfg_reg[g].output_mode && !(src_value[g] ^ cfg_reg[g].invert));
        rail_next[g] = cfg_reg[g].aux_rail && AUX_RAIL_CAPABLE[g];
      end
    end
  endgenerate

  // Single snapshot so all bits come from the same cycle
  assign all_pin_levels = level_vec;

  // Register writes land at the edge that completes the handshake
  always_comb
  begin
    io_line_index_next = io_line_index_reg;
    input_filter_choice_next = input_filter_choice_reg;
    soft_out_index_next = soft_out_index_reg;
    soft_next = soft_reg;
    for (int i = 0; i < LINES; i++)
      cfg_next[i] = cfg_reg[i];
    if (wr)
    begin
      if (avs_address == cgl_pkg::OFF_LINE_INDEX)
        io_line_index_next = avs_writedata[1:0];
      else if (avs_address == cgl_pkg::OFF_LINE_MODE)
        cfg_next[sel].output_mode = avs_writedata[0];
      else if (avs_address == cgl_pkg::OFF_AUX_RAIL)
        cfg_next[sel].aux_rail = avs_writedata[0] && AUX_RAIL_CAPABLE[sel];
      else if (avs_address == cgl_pkg::OFF_INVERT)
        cfg_next[sel].invert = avs_writedata[0];
      else if (avs_address == cgl_pkg::OFF_FILTER_CHOICE)
        input_filter_choice_next = avs_writedata[0];
      else if (avs_address == cgl_pkg::OFF_FILTER_WIDTH && avs_byteenable[1])
      begin
        if (input_filter_choice_reg == cgl_pkg::FILTER_DEBOUNCE)
          cfg_next[sel].debounce_us = avs_writedata[15:0];
        else
          cfg_next[sel].deglitch_us = avs_writedata[15:0];
      end
      else if (avs_address == cgl_pkg::OFF_SOURCE && avs_writedata[3:0] <= cgl_pkg::SRC_LAST)
        cfg_next[sel].source = avs_writedata[3:0];
      else if (avs_address == cgl_pkg::OFF_SOFT_INDEX)
        soft_out_index_next = avs_writedata[1:0];
      else if (avs_address == cgl_pkg::OFF_SOFT_LEVEL)
        soft_next[soft_out_index_reg] = avs_writedata[0];
      else if (avs_address == cgl_pkg::OFF_SOFT_VECTOR)
        soft_next = avs_writedata[USER_OUTS-1:0];
    end
  end

  // One access per two cycles: taken when idle, answered from the done state
  always_comb
  begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    if (state_reg == ST_DONE)
      state_next = ST_IDLE;
    else if (avs_read || avs_write)
      state_next = ST_DONE;
    // Registered so the bus sees waitrequest straight from a flop
    wait_next = (state_next != ST_DONE);
    if (rd)
    begin
      rdata_next = cgl_pkg::UNMAPPED_READ;
      if (avs_address == cgl_pkg::OFF_LINE_INDEX)
        rdata_next[1:0] = io_line_index_reg;
      else if (avs_address == cgl_pkg::OFF_LINE_MODE)
        rdata_next[0] = sel_cfg.output_mode;
      else if (avs_address == cgl_pkg::OFF_AUX_RAIL)
        rdata_next[0] = sel_cfg.aux_rail;
      else if (avs_address == cgl_pkg::OFF_INVERT)
        rdata_next[0] = sel_cfg.invert;
      else if (avs_address == cgl_pkg::OFF_LEVEL)
        rdata_next[0] = level_vec[sel];
      else if (avs_address == cgl_pkg::OFF_ALL_LEVELS)
        rdata_next[LINES-1:0] = all_pin_levels;
      else if (avs_address == cgl_pkg::OFF_FILTER_CHOICE)
        rdata_next[0] = input_filter_choice_reg;
      else if (avs_address == cgl_pkg::OFF_FILTER_WIDTH)
        rdata_next[15:0] = input_filter_choice_reg ? sel_cfg.debounce_us : sel_cfg.deglitch_us;
      else if (avs_address == cgl_pkg::OFF_SOURCE)
        rdata_next[3:0] = sel_cfg.source;
      else if (avs_address == cgl_pkg::OFF_DRIVER_KIND)
        rdata_next[1:0] = DRIVER_KINDS[2*sel +: 2];
      else if (avs_address == cgl_pkg::OFF_SOFT_INDEX)
        rdata_next[1:0] = soft_out_index_reg;
      else if (avs_address == cgl_pkg::OFF_SOFT_LEVEL)
        rdata_next[0] = soft_reg[soft_out_index_reg];
      else if (avs_address == cgl_pkg::OFF_SOFT_VECTOR)
        rdata_next[USER_OUTS-1:0] = soft_reg;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      io_line_index_reg <= '0;
      input_filter_choice_reg <= cgl_pkg::FILTER_DEGLITCH;
      soft_out_index_reg <= '0;
      soft_reg <= '0;
      for (int i = 0; i < LINES; i++)
        cfg_reg[i] <= cgl_pkg::LINE_CFG_RESET;
    end
    else
    begin
      io_line_index_reg <= io_line_index_next;
      input_filter_choice_reg <= input_filter_choice_next;
      soft_out_index_reg <= soft_out_index_next;
      soft_reg <= soft_next;
      for (int i = 0; i < LINES; i++)
        cfg_reg[i] <= cfg_next[i];
    end
  end

  // Pins come out of reset released; open drain never drives high
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      in_sync_reg <= '0;
      drive_reg <= '0;
      oe_n_reg <= '1;
      rail_reg <= '0;
    end
    else
    begin
      in_sync_reg <= pin_in;
      drive_reg <= drive_next;
      oe_n_reg <= oe_n_next;
      rail_reg <= rail_next;
    end
  end

  // Waitrequest drops in the cycle after the request is seen
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign pin_out = drive_reg;
  assign pin_oe_n = oe_n_reg;
  assign aux_rail_enable = rail_reg;
  assign soft_out_vector = soft_reg;
endmodule : cgl_gpio_lines
`default_nettype wire

// file: sim/cgl_gpio_lines_properties.sv
// Port-level checks for the GPIO line control block
`timescale 1ns/1ns
`default_nettype none
module cgl_gpio_lines_props #(
  parameter int LINES = 4,
  parameter int USER_OUTS = 4,
  parameter logic [LINES-1:0] AUX_RAIL_CAPABLE = 4'h4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [LINES-1:0] pin_out,
  input wire logic [LINES-1:0] pin_oe_n,
  input wire logic [LINES-1:0] aux_rail_enable,
  input wire logic [USER_OUTS-1:0] soft_out_vector
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_vec_wr;
    avs_write && !avs_waitrequest && avs_address == cgl_pkg::OFF_SOFT_VECTOR && avs_byteenable[0];
  endsequence
  AST_ANSWER: assert property (s_req |-> ##[1:2] !avs_waitrequest)
    else $error("request not answered");
  AST_WAIT_PULSE: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > cgl_pkg::OFF_SOFT_VECTOR
    |-> avs_readdata == '0) else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!$stable(avs_readdata) |-> $past(avs_read))
    else $error("read data moved without a read");
  AST_VEC_WR: assert property (s_vec_wr |=> soft_out_vector == $past(avs_writedata[USER_OUTS-1:0]))
    else $error("user word not applied");
  AST_VEC_HOLD: assert property (!$stable(soft_out_vector) |-> $past(avs_write))
    else $error("user outputs moved without a write");
  AST_AUX_ONLY: assert property ((aux_rail_enable & ~AUX_RAIL_CAPABLE) == '0)
    else $error("aux rail on incapable line");
  AST_PIN_LOW: assert property (pin_out == '0)
    else $error("open drain drives high");
  AST_RST_OE: assert property ($fell(rst) |-> pin_oe_n == '1)
    else $error("pin driven out of reset");
endmodule : cgl_gpio_lines_props
bind cgl_gpio_lines cgl_gpio_lines_props #(.LINES(LINES), .USER_OUTS(USER_OUTS),
  .AUX_RAIL_CAPABLE(AUX_RAIL_CAPABLE)) cgl_gpio_lines_props_inst (.clock(clock), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .aux_rail_enable(aux_rail_enable), .soft_out_vector(soft_out_vector));
`default_nettype wire

// file: sim/cgl_pin_partner.sv
// Connector-side model: pull-ups and external open-drain pulldowns
`timescale 1ns/1ns
`default_nettype none
module cgl_pin_partner #(
  parameter int LINES = 4
) (
  input wire logic [LINES-1:0] pin_oe_n,
  input wire logic [LINES-1:0] ext_low,
  output logic [LINES-1:0] pin_in
);
  // Released wire floats high through the pull-up
  assign pin_in = pin_oe_n & ~ext_low;
endmodule : cgl_pin_partner
`default_nettype wire

// file: sim/cgl_gpio_lines_tb_top.sv
// Self-checking bench for the GPIO line control block
`timescale 1ns/1ns
`default_nettype none
module cgl_gpio_lines_tb_top;
  localparam logic [3:0] AUX_CAP = 4'h4;
  localparam logic [7:0] KINDS = 8'h25;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] pin_in;
  logic [3:0] pin_out;
  logic [3:0] pin_oe_n;
  logic [3:0] aux_rail_enable;
  logic [3:0] soft_out_vector;
  logic [3:0] ext_low = 4'h0;
  cgl_pkg::cgl_internal_type internal_in = '0;
  int n_fail = 0;
  int checked = 0;
  logic [31:0] rdata;
  logic [3:0] srcs [6] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
  logic [5:0] hits [6] = '{6'h10, 6'h20, 6'h04, 6'h08, 6'h02, 6'h01};
  cgl_gpio_lines #(.AUX_RAIL_CAPABLE(AUX_CAP), .DRIVER_KINDS(KINDS)) cgl_gpio_lines_inst (.clock(clock), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .aux_rail_enable(aux_rail_enable),
    .internal_in(internal_in), .soft_out_vector(soft_out_vector));
  cgl_pin_partner cgl_pin_partner_inst (.pin_oe_n(pin_oe_n), .ext_low(ext_low), .pin_in(pin_in));
  initial
  begin
    forever #4 clock = ~clock;
  end
  task automatic final_report();
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Request stands until waitrequest is seen low at a rising edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int k;
    @(posedge clock);
    avs_address <= addr;
    avs_writedata <= wdata;
    avs_write <= wr;
    avs_read <= !wr;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (k == 50)
    begin
      n_fail++;
      final_report();
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : access
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    access(1'b1, a, d);
  endtask : put
  task automatic get(input logic [7:0] a);
    access(1'b0, a, 32'h0);
  endtask : get
  // Ends on a rising edge; outputs read there still show the value before it
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
  endtask : settle
  task automatic level_is(input string what, input logic [31:0] exp);
    get(cgl_pkg::OFF_LEVEL);
    chk(what, rdata, exp);
  endtask : level_is
  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // Pin register and both filter stages lag the pins by a few edges
    settle(4);
    get(cgl_pkg::OFF_ALL_LEVELS);
    chk("all levels", rdata, 32'h0000000F);
    get(8'h40);
    chk("unmapped", rdata, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      put(cgl_pkg::OFF_LINE_INDEX, 32'(i));
      put(cgl_pkg::OFF_AUX_RAIL, 32'h1);
      get(cgl_pkg::OFF_DRIVER_KIND);
      chk("driver kind", rdata, {30'h0, KINDS[2*i+:2]});
    end
    settle(2);
    chk("aux rail", 32'(aux_rail_enable), 32'(AUX_CAP));
    ext_low <= 4'h2;
    settle(4);
    get(cgl_pkg::OFF_ALL_LEVELS);
    chk("all levels", rdata, 32'h0000000D);
    put(cgl_pkg::OFF_LINE_INDEX, 32'h1);
    level_is("line level", 32'h0);
    put(cgl_pkg::OFF_INVERT, 32'h1);
    settle(4);
    level_is("inverted level", 32'h1);
    put(cgl_pkg::OFF_INVERT, 32'h0);
    ext_low <= 4'h0;
    // Deglitch on line 0, one microsecond is 125 cycles
    put(cgl_pkg::OFF_LINE_INDEX, 32'h0);
    put(cgl_pkg::OFF_FILTER_CHOICE, 32'h0);
    put(cgl_pkg::OFF_FILTER_WIDTH, 32'h1);
    ext_low <= 4'h1;
    settle(100);
    ext_low <= 4'h0;
    settle(150);
    level_is("glitch", 32'h1);
    ext_low <= 4'h1;
    settle(100);
    level_is("before width", 32'h1);
    settle(60);
    level_is("after width", 32'h0);
    put(cgl_pkg::OFF_LINE_INDEX, 32'h3);
    put(cgl_pkg::OFF_FILTER_CHOICE, 32'h1);
    put(cgl_pkg::OFF_FILTER_WIDTH, 32'h1);
    ext_low <= 4'h9;
    settle(4);
    level_is("first edge", 32'h0);
    ext_low <= 4'h1;
    settle(40);
    level_is("bounce", 32'h0);
    settle(150);
    level_is("debounced", 32'h1);
    put(cgl_pkg::OFF_SOFT_INDEX, 32'h2);
    put(cgl_pkg::OFF_SOFT_LEVEL, 32'h1);
    settle(1);
    chk("soft level", 32'(soft_out_vector), 32'h4);
    put(cgl_pkg::OFF_SOFT_VECTOR, 32'hA);
    get(cgl_pkg::OFF_SOFT_VECTOR);
    chk("soft vector", rdata, 32'hA);
    chk("soft port", 32'(soft_out_vector), 32'hA);
    put(cgl_pkg::OFF_LINE_INDEX, 32'h1);
    put(cgl_pkg::OFF_LINE_MODE, 32'h1);
    put(cgl_pkg::OFF_SOURCE, 32'h5);
    settle(3);
    chk("user source", 32'(pin_oe_n[1]), 32'h1);
    for (int j = 0; j < 6; j++)
    begin
      put(cgl_pkg::OFF_SOURCE, {28'h0, srcs[j]});
      internal_in <= hits[j];
      settle(3);
      chk("source high", 32'(pin_oe_n[1]), 32'h1);
      internal_in <= 6'h00;
      settle(3);
      chk("source low", 32'(pin_oe_n[1]), 32'h0);
    end
    // Line 0 still has its deglitch width, so the loop lags it
    put(cgl_pkg::OFF_SOURCE, 32'h0);
    ext_low <= 4'h0;
    settle(200);
    chk("loop high", 32'(pin_oe_n[1]), 32'h1);
    ext_low <= 4'h1;
    settle(200);
    chk("loop low", 32'(pin_oe_n[1]), 32'h0);
    put(cgl_pkg::OFF_INVERT, 32'h1);
    settle(3);
    chk("inverted out", 32'(pin_oe_n[1]), 32'h1);
    put(cgl_pkg::OFF_INVERT, 32'h0);
    put(cgl_pkg::OFF_LINE_MODE, 32'h0);
    settle(3);
    chk("input mode", 32'(pin_oe_n[1]), 32'h1);
    final_report();
  end
endmodule : cgl_gpio_lines_tb_top
`default_nettype wire
